/* File: logic/vst_pkg.sv */
// Purpose: shared constants and types for the video sync and trigger block
// Assumes: 100 MHz system clock, 32-bit classic Wishbone register port
// Notes: offsets are byte addresses, one aligned word per register
package vst_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_HCOUNT = 8'h04;
    localparam logic [7:0] ADDR_LINES = 8'h08;
    localparam logic [7:0] ADDR_PULSE = 8'h0C;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // field widths and positions
    localparam int HCOUNT_W = 11;
    localparam int LINES_W = 10;
    localparam int PULSE_W = 16;
    localparam int PERIOD_W = 16;
    localparam int PIX_W = 8;
    localparam int CTRL_W = 8;
    localparam int CMD_FIRE_BIT = 0;
    localparam int ST_TRIGGER_LINE_BIT = 0;
    localparam int ST_LINE_BIT = 1;
    localparam int ST_FRAME_BIT = 2;
    localparam int ST_RATE_BIT = 3;
    localparam int ST_PERIOD_LSB = 16;

    // reset values and the 525 and 625 line counts
    localparam logic [HCOUNT_W-1:0] HCOUNT_RST = 11'h30C;
    localparam logic [LINES_W-1:0] LINES_RST = 10'h20D;
    localparam logic [PULSE_W-1:0] PULSE_RST = 16'h0001;
    localparam logic [LINES_W-1:0] LINES_525 = 10'h20D;
    localparam logic [LINES_W-1:0] LINES_625 = 10'h271;

    // timing, in printed units, and derived cycle counts
    localparam int CLK_KHZ = 100000;
    localparam int MIN_PULSE_NS = 50;
    localparam int LINE_MIN_NS = 40000;
    localparam int VSYNC_MIN_NS = 10000;
    localparam int PIX_MIN_HZ10 = 1166;
    localparam int PIX_MAX_MHZ = 31;
    localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * CLK_KHZ + 999999) / 1000000;
    // the product overflows a 32-bit int, so this one is reckoned in 64 bits
    localparam int LINE_MIN_CYC = int'((longint'(LINE_MIN_NS) * CLK_KHZ + 999999) / 1000000);
    localparam int VSYNC_MIN_CYC = (VSYNC_MIN_NS * CLK_KHZ + 999999) / 1000000;

    // trigger output sources
    typedef enum logic [1:0]
    {
        TSRC_LEVEL = 2'b00,
        TSRC_COMPOSITE_SYNC = 2'b01,
        TSRC_VSYNC = 2'b10,
        TSRC_PULSE = 2'b11
    } vst_tsrc_t;

    // control register layout, bit 0 at the bottom
    typedef struct packed
    {
        logic trigLevel;
        vst_tsrc_t trigSrc;
        logic trigRise;
        logic trigDirOut;
        logic csyncRise;
        logic csyncDirOut;
        logic extMode;
    } vst_ctrl_t;

    localparam vst_ctrl_t CTRL_RST = '0;
endpackage

/* File: logic/vst_sync_trigger.sv */
// Purpose: sync separation, genlocked pixel strobe and trigger line control
// Assumes: sync tip comparator and 8-bit ADC samples arrive on asynchronous pins
// Notes: pin output enables are active low; all outputs come from flip-flops
// Function
// - standard mode: sync from video yields composite, line, field sync and pixel clock
// - external mode: line, field sync and pixel clock come from external composite sync
// - composite sync pin direction set by a software control bit
// - standard mode may drive internal composite sync out on its pin
// - composite sync input polarity selects rising or falling edge as sync
// - trigger pin is an acquisition start input or an output
// - trigger input detects rising or falling edge as programmed
// - trigger output level set directly by software
// - trigger output may carry internal sync events or a programmed-width pulse
// - pixels delivered as unsigned 8-bit gray values
// - pixel clock rate settable from 11.66 MHz to 31 MHz
// - locks to interlaced 25/30 and progressive 25/30/50/60 frame rates
// - pixel clock rate follows programmed pixels per line
// - line count register switches between 525 and 625 lines
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module vst_sync_trigger
    import vst_pkg::*;
#(
    parameter logic [HCOUNT_W-1:0] HCOUNT_DEFAULT = HCOUNT_RST,
    parameter logic [LINES_W-1:0] LINES_DEFAULT = LINES_RST
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // video front end
    input wire logic videoSyncTip,
    input wire logic [PIX_W-1:0] adcSample,
    // composite sync pin
    input wire logic compSyncIn,
    output logic compSyncOut,
    output logic compSyncOen,
    // trigger pin
    input wire logic trigIn,
    output logic trigOut,
    output logic trigOen,
    // capture side
    output logic [PIX_W-1:0] pixData,
    output logic pixValid,
    output logic hsyncPulse,
    output logic vsyncPulse,
    output logic acqStart
);
    vst_ctrl_t ctrl_reg;
    logic [HCOUNT_W-1:0] hCount_reg;
    logic [LINES_W-1:0] lineCount_reg;
    logic [PULSE_W-1:0] pulseWidth_reg;
    logic trigSeen_reg;
    logic lineLocked_reg;
    logic frameLocked_reg;
    logic rateOk_reg;
    logic [2:0] tipSync;
    logic [2:0] csSync;
    logic [2:0] trSync;
    logic [PIX_W-1:0] pixSync1;
    logic [PIX_W-1:0] pixSync2;
    logic syncLevel;
    logic syncPrev_reg;
    logic syncLead;
    logic [PERIOD_W-1:0] lineTimer_reg;
    logic [PERIOD_W-1:0] linePeriod_reg;
    logic [PERIOD_W-1:0] syncWidth_reg;
    logic lineEdge;
    logic inVsync_reg;
    logic [LINES_W:0] linesInField_reg;
    logic [PERIOD_W:0] pixAcc_reg;
    logic [PERIOD_W:0] pixAcc_next;
    logic [7:0] trStable_reg;
    logic trFiltered_reg;
    logic trPrev_reg;
    logic trigEdge;
    logic [PULSE_W-1:0] pulseLeft_reg;
    logic wbReq;
    logic wbWrite;
    logic [31:0] statusWord;
    logic [LINES_W-1:0] halfLines;

    // byte-lane merge so partial writes leave the other lanes alone
    function automatic logic [31:0] mergeSel(input logic [31:0] old, input logic [31:0] din,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                res[b*8 +: 8] = din[b*8 +: 8];
            end
        end
        return res;
    endfunction

    assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wbWrite = wbReq && wb_we_i;

    // pin synchronisers: the first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            tipSync <= 3'h0;
            csSync <= 3'h0;
            trSync <= 3'h0;
            pixSync1 <= 8'h00;
            pixSync2 <= 8'h00;
        end
        else
        begin
            tipSync <= {tipSync[1:0], videoSyncTip};
            csSync <= {csSync[1:0], compSyncIn};
            trSync <= {trSync[1:0], trigIn};
            pixSync1 <= adcSample;
            pixSync2 <= pixSync1;
        end
    end

    // sync source: own separator or external pin with chosen polarity
    always_comb
    begin
        if (ctrl_reg.extMode)
        begin
            syncLevel = ctrl_reg.csyncRise ? csSync[1] : !csSync[1];
        end
        else
        begin
            syncLevel = tipSync[1];
        end
    end

    assign syncLead = syncLevel && !syncPrev_reg;
    // half-line equalising pulses are ignored by the minimum line length
    assign lineEdge = syncLead && (lineTimer_reg >= PERIOD_W'(LINE_MIN_CYC));

    // line timing: period between accepted leading edges, sync width
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            syncPrev_reg <= 1'b0;
            lineTimer_reg <= 16'h0000;
            linePeriod_reg <= 16'h0000;
            syncWidth_reg <= 16'h0000;
        end
        else
        begin
            syncPrev_reg <= syncLevel;
            if (lineEdge)
            begin
                linePeriod_reg <= lineTimer_reg;
                lineTimer_reg <= 16'h0001;
            end
            else if (lineTimer_reg != 16'hFFFF)
            begin
                lineTimer_reg <= lineTimer_reg + 16'h0001;
            end
            if (!syncLevel)
            begin
                syncWidth_reg <= 16'h0000;
            end
            else if (syncWidth_reg != 16'hFFFF)
            begin
                syncWidth_reg <= syncWidth_reg + 16'h0001;
            end
        end
    end

    // broad sync pulses mark the field; one field pulse per interval
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            inVsync_reg <= 1'b0;
            vsyncPulse <= 1'b0;
            hsyncPulse <= 1'b0;
            linesInField_reg <= 11'h000;
        end
        else
        begin
            hsyncPulse <= lineEdge;
            vsyncPulse <= 1'b0;
            if (syncWidth_reg == PERIOD_W'(VSYNC_MIN_CYC) && !inVsync_reg)
            begin
                inVsync_reg <= 1'b1;
                vsyncPulse <= 1'b1;
                linesInField_reg <= 11'h000;
            end
            else if (lineEdge)
            begin
                if (syncWidth_reg < PERIOD_W'(VSYNC_MIN_CYC))
                begin
                    inVsync_reg <= 1'b0;
                end
                linesInField_reg <= linesInField_reg + 11'h001;
            end
        end
    end

    // lock checks: interlaced fields hold half a frame, progressive all of it
    assign halfLines = lineCount_reg >> 1;
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            frameLocked_reg <= 1'b0;
            lineLocked_reg <= 1'b0;
            rateOk_reg <= 1'b0;
        end
        else
        begin
            lineLocked_reg <= lineEdge ? 1'b1 : (lineTimer_reg == 16'hFFFF ? 1'b0 : lineLocked_reg);
            // judged on the field's count before the field pulse clears it
            if (syncWidth_reg == PERIOD_W'(VSYNC_MIN_CYC) && !inVsync_reg)
            begin
                frameLocked_reg <= (linesInField_reg == {1'b0, halfLines})
                    || (linesInField_reg == {1'b0, halfLines} + 11'h001)
                    || (linesInField_reg == {1'b0, lineCount_reg});
            end
            // pixel rate = hCount * clock / period, checked against its range
            rateOk_reg <= (48'(hCount_reg) * 48'(CLK_KHZ / 10) >= 48'(linePeriod_reg)
                * 48'(PIX_MIN_HZ10)) && (48'(hCount_reg) * 48'(CLK_KHZ / 1000)
                <= 48'(linePeriod_reg) * 48'(PIX_MAX_MHZ));
        end
    end

    // genlocked pixel strobe: hCount strobes spread evenly over one line
    always_comb
    begin
        pixAcc_next = pixAcc_reg + 17'(hCount_reg);
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pixAcc_reg <= 17'h00000;
            pixValid <= 1'b0;
            pixData <= 8'h00;
        end
        else
        begin
            pixValid <= 1'b0;
            if (lineEdge)
            begin
                pixAcc_reg <= 17'h00000; // phase realigned each line
            end
            else if (lineLocked_reg && linePeriod_reg != 16'h0000
                     && pixAcc_next >= {1'b0, linePeriod_reg})
            begin
                pixAcc_reg <= pixAcc_next - {1'b0, linePeriod_reg};
                pixValid <= 1'b1;
                pixData <= pixSync2;
            end
            else if (lineLocked_reg)
            begin
                pixAcc_reg <= pixAcc_next;
            end
        end
    end

    // trigger input: level must stand the minimum width before it counts
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            trStable_reg <= 8'h00;
            trFiltered_reg <= 1'b0;
            trPrev_reg <= 1'b0;
        end
        else
        begin
            trPrev_reg <= trFiltered_reg;
            if (trSync[2] == trSync[1])
            begin
                if (trStable_reg == 8'(MIN_PULSE_CYC - 1))
                begin
                    trFiltered_reg <= trSync[1];
                end
                else
                begin
                    trStable_reg <= trStable_reg + 8'h01;
                end
            end
            else
            begin
                trStable_reg <= 8'h00;
            end
        end
    end

    assign trigEdge = !ctrl_reg.trigDirOut && (ctrl_reg.trigRise
        ? (trFiltered_reg && !trPrev_reg) : (!trFiltered_reg && trPrev_reg));

    // acquisition start pulse and sticky seen flag; set beats clear
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            acqStart <= 1'b0;
            trigSeen_reg <= 1'b0;
        end
        else
        begin
            acqStart <= trigEdge;
            if (trigEdge)
            begin
                trigSeen_reg <= 1'b1;
            end
            else if (wbWrite && wb_adr_i == ADDR_STATUS && wb_sel_i[0]
                     && wb_dat_i[ST_TRIGGER_LINE_BIT])
            begin
                trigSeen_reg <= 1'b0;
            end
        end
    end

    // programmed pulse: a fire command loads the width counter
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pulseLeft_reg <= 16'h0000;
        end
        else if (wbWrite && wb_adr_i == ADDR_CMD && wb_sel_i[0] && wb_dat_i[CMD_FIRE_BIT])
        begin
            pulseLeft_reg <= pulseWidth_reg;
        end
        else if (pulseLeft_reg != 16'h0000)
        begin
            pulseLeft_reg <= pulseLeft_reg - 16'h0001;
        end
    end

    // pin drivers; enables low while driving, released at reset
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            compSyncOut <= 1'b0;
            compSyncOen <= 1'b1;
            trigOut <= 1'b0;
            trigOen <= 1'b1;
        end
        else
        begin
            // external mode needs the pin as input, so it never drives there
            compSyncOen <= !(ctrl_reg.csyncDirOut && !ctrl_reg.extMode);
            compSyncOut <= tipSync[1];
            trigOen <= !ctrl_reg.trigDirOut;
            case (ctrl_reg.trigSrc)
                TSRC_LEVEL: trigOut <= ctrl_reg.trigLevel;
                TSRC_COMPOSITE_SYNC: trigOut <= syncLevel;
                TSRC_VSYNC: trigOut <= inVsync_reg;
                default: trigOut <= (pulseLeft_reg != 16'h0000);
            endcase
        end
    end

    // register writes
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_reg <= CTRL_RST;
            hCount_reg <= HCOUNT_DEFAULT;
            lineCount_reg <= LINES_DEFAULT;
            pulseWidth_reg <= PULSE_RST;
        end
        else if (wbWrite)
        begin
            if (wb_adr_i == ADDR_CTRL)
            begin
                ctrl_reg <= vst_ctrl_t'(CTRL_W'(mergeSel(32'(ctrl_reg), wb_dat_i, wb_sel_i)));
            end
            else if (wb_adr_i == ADDR_HCOUNT)
            begin
                hCount_reg <= HCOUNT_W'(mergeSel(32'(hCount_reg), wb_dat_i, wb_sel_i));
            end
            else if (wb_adr_i == ADDR_LINES)
            begin
                lineCount_reg <= LINES_W'(mergeSel(32'(lineCount_reg), wb_dat_i, wb_sel_i));
            end
            else if (wb_adr_i == ADDR_PULSE)
            begin
                pulseWidth_reg <= PULSE_W'(mergeSel(32'(pulseWidth_reg), wb_dat_i, wb_sel_i));
            end
        end
    end

    assign statusWord = {linePeriod_reg, 12'h000, rateOk_reg, frameLocked_reg,
                         lineLocked_reg, trigSeen_reg};

    // one-wait-state answer; unmapped addresses read zero, writes dropped
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wbReq;
            if (!wbReq || wb_we_i)
            begin
                wb_dat_o <= 32'h00000000;
            end
            else if (wb_adr_i == ADDR_CTRL)
            begin
                wb_dat_o <= 32'(ctrl_reg);
            end
            else if (wb_adr_i == ADDR_HCOUNT)
            begin
                wb_dat_o <= 32'(hCount_reg);
            end
            else if (wb_adr_i == ADDR_LINES)
            begin
                wb_dat_o <= 32'(lineCount_reg);
            end
            else if (wb_adr_i == ADDR_PULSE)
            begin
                wb_dat_o <= 32'(pulseWidth_reg);
            end
            else if (wb_adr_i == ADDR_STATUS)
            begin
                wb_dat_o <= statusWord;
            end
            else
            begin
                wb_dat_o <= 32'h00000000;
            end
        end
    end
endmodule

/* File: sim/vst_sync_trigger_sva.sv */
// Purpose: port checks for the sync and trigger block
// Assumes: one clock domain, reset active low
// Notes: line spacing is tracked by a small saturating counter
`timescale 1ns/1ps
module vst_sync_trigger_sva
    import vst_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pins and pulses
    input wire logic compSyncOen,
    input wire logic trigOen,
    input wire logic hsyncPulse,
    input wire logic vsyncPulse,
    input wire logic pixValid,
    input wire logic acqStart
);
    logic [12:0] gapReg;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // cycles since the last line pulse; saturates so a dead line stays legal
    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            gapReg <= 13'h1FFF;
        else if (hsyncPulse)
            gapReg <= 13'h0001;
        else if (gapReg != 13'h1FFF)
            gapReg <= gapReg + 13'h0001;

    // one bus request and its single-cycle answer
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_pins_released: assert property ($rose(rstn) |-> compSyncOen && trigOen)
        else $error("pin enabled right after reset");
    a_ack_answer: assert property (s_req |=> s_answer)
        else $error("bus answer late or too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without request");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_line_single: assert property (hsyncPulse |=> !hsyncPulse)
        else $error("line pulse too long");
    a_line_spacing: assert property (hsyncPulse |-> gapReg >= 13'h0F9F)
        else $error("line pulses too close");
    a_field_single: assert property (vsyncPulse |=> !vsyncPulse)
        else $error("field pulse too long");
    a_pix_locked: assert property (pixValid |-> gapReg != 13'h1FFF)
        else $error("pixel strobe without line lock");
    a_acq_input: assert property (acqStart |-> trigOen)
        else $error("acquisition start while trigger drives");
    a_acq_spacing: assert property (acqStart |=> !acqStart [*4])
        else $error("acquisition starts too close");
endmodule

bind vst_sync_trigger vst_sync_trigger_sva i_vst_sync_trigger_sva (
    .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .compSyncOen(compSyncOen),
    .trigOen(trigOen), .hsyncPulse(hsyncPulse), .vsyncPulse(vsyncPulse),
    .pixValid(pixValid), .acqStart(acqStart)
);

/* File: sim/vst_camera_model.sv */
// Purpose: camera and sync source facing the block
// Assumes: raster timed in system clock cycles
// Notes: one broad pulse per short field keeps runs brief
`timescale 1ns/1ps
module vst_camera_model
    import vst_pkg::*;
#(
    parameter int LINE_CYC = 5000,
    parameter int TIP_CYC = 470,
    parameter int BROAD_CYC = 1200,
    parameter int FIELD_LINES = 4
)
(
    // clock
    input wire logic clk_sys,
    // settings from the bench
    input wire logic lumaOnly,
    input wire logic syncInv,
    input wire logic trigToggle,
    // pins toward the block
    output logic videoSyncTip,
    output logic [PIX_W-1:0] adcSample,
    output logic camSync,
    output logic trigDrv
);
    int pos = 0;
    int lineNo = 0;
    logic inSync;

    // free-running raster
    always @(posedge clk_sys)
    begin
        pos <= (pos == LINE_CYC - 1) ? 0 : pos + 1;
        if (pos == LINE_CYC - 1)
            lineNo <= (lineNo == FIELD_LINES - 1) ? 0 : lineNo + 1;
    end
    assign inSync = pos < ((lineNo == 0) ? BROAD_CYC : TIP_CYC);
    // luma-only video carries no sync tip, so sync must come from the pin
    assign videoSyncTip = inSync && !lumaOnly;
    assign camSync = inSync ^ syncInv;
    assign adcSample = inSync ? 8'h00 : 8'hA5;
    // each toggle is an edge held far longer than the minimum width
    initial trigDrv = 1'b0;
    always @(posedge clk_sys)
        if (trigToggle)
            trigDrv <= !trigDrv;
endmodule

/* File: sim/testbench.sv */
// Purpose: self-checking bench for the sync and trigger block
// Assumes: camera model supplies sync, video and trigger edges
// Notes: windows span whole fields so pulse counts are exact
`timescale 1ns/1ps
module testbench
    import vst_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDat = 32'h0, wbDatO, q;
    logic wbAck, videoSyncTip, compSyncIn, compSyncOut, compSyncOen;
    logic trigIn, trigOut, trigOen, camSync, trigDrv;
    logic pixValid, hsyncPulse, vsyncPulse, acqStart;
    logic lumaOnly = 1'b0, syncInv = 1'b0, trigToggle = 1'b0;
    logic [PIX_W-1:0] adcSample, pixData;
    int error_cnt = 0, cmp_count = 0;
    int nH, nV, nP, nT, nA, nBad, nC;

    // clock
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end
    // pin level from whichever side drives; enables are active low
    assign compSyncIn = compSyncOen ? camSync : compSyncOut;
    assign trigIn = trigOen ? trigDrv : trigOut;

    vst_sync_trigger i_vst_sync_trigger (
        .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .videoSyncTip(videoSyncTip),
        .adcSample(adcSample), .compSyncIn(compSyncIn), .compSyncOut(compSyncOut),
        .compSyncOen(compSyncOen), .trigIn(trigIn), .trigOut(trigOut), .trigOen(trigOen),
        .pixData(pixData), .pixValid(pixValid), .hsyncPulse(hsyncPulse),
        .vsyncPulse(vsyncPulse), .acqStart(acqStart)
    );
    vst_camera_model i_vst_camera_model (
        .clk_sys(clk_sys), .lumaOnly(lumaOnly), .syncInv(syncInv),
        .trigToggle(trigToggle), .videoSyncTip(videoSyncTip), .adcSample(adcSample),
        .camSync(camSync), .trigDrv(trigDrv)
    );

    task automatic test_done();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic wbXfer(input logic [7:0] a, input logic we, input logic [31:0] d);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDat <= d;
        wbSel <= 4'hF;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (wbAck !== 1'b1 && n < 50);
        chk("ack", 32'h1, wbAck);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wbXfer(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wbXfer(a, 1'b0, 32'h0);
        chk($sformatf("reg %h", a), e, q);
    endtask

    // counts pulses over n edges, sampling the values each edge sees
    task automatic watch(input int n);
        {nH, nV, nP, nT, nA, nBad, nC} = '0;
        repeat (n)
        begin
            nH += int'(hsyncPulse === 1'b1);
            nV += int'(vsyncPulse === 1'b1);
            nP += int'(pixValid === 1'b1);
            nT += int'(trigOut === 1'b1);
            nA += int'(acqStart === 1'b1);
            nC += int'(compSyncOut === 1'b1);
            if (pixValid === 1'b1 && pixData !== 8'hA5 && pixData !== 8'h00)
                nBad++;
            @(posedge clk_sys);
        end
    endtask

    task automatic tog();
        trigToggle <= 1'b1;
        @(posedge clk_sys);
        trigToggle <= 1'b0;
        watch(30);
    endtask

    task automatic tSync(input logic ext, input logic [31:0] hc, input logic rate,
        input logic [31:0] lines, input logic frame);
        lumaOnly <= ext;
        syncInv <= ext;
        wr(ADDR_LINES, lines);
        wr(ADDR_HCOUNT, hc);
        wr(ADDR_CTRL, ext ? 32'h03 : 32'h02);
        watch(6000);
        watch(20000);
        chk("lines", 32'h4, nH);
        chk("fields", 32'h1, nV);
        chk("pixels", 32'h1, 32'(nP > 4 * hc - 20 && nP < 4 * hc + 20));
        chk("gray", 32'h0, nBad);
        chk("csyncOut", ext ? 32'h0 : 32'hA32, nC);
        chk("csyncOen", ext, compSyncOen);
        wbXfer(ADDR_STATUS, 1'b0, 32'h0);
        chk("period", 32'h1388, q[31:16]);
        chk("lineLock", 32'h1, q[ST_LINE_BIT]);
        chk("rateOk", rate, q[ST_RATE_BIT]);
        chk("frameLock", frame, q[ST_FRAME_BIT]);
    endtask

    task automatic tTrigIn(input logic rise);
        wr(ADDR_CTRL, rise ? 32'h10 : 32'h00);
        tog();
        chk("acqUp", rise, nA);
        tog();
        chk("acqDown", !rise, nA);
        wbXfer(ADDR_STATUS, 1'b0, 32'h0);
        chk("seen", 32'h1, q[ST_TRIGGER_LINE_BIT]);
        wr(ADDR_STATUS, 32'h1);
        wbXfer(ADDR_STATUS, 1'b0, 32'h0);
        chk("cleared", 32'h0, q[ST_TRIGGER_LINE_BIT]);
    endtask

    task automatic tOut(input logic [31:0] c, input logic [31:0] w, input int lo,
        input int hi, input int n);
        wr(ADDR_CTRL, c);
        if (c[6:5] == 2'b11)
        begin
            wr(ADDR_PULSE, w);
            wr(ADDR_CMD, 32'h1);
        end
        watch(n);
        chk("trigOen", 32'h0, trigOen);
        chk("trigHigh", 32'h1, 32'(nT >= lo && nT <= hi));
    endtask

    // main sequence
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        chk("csyncOen", 32'h1, compSyncOen);
        chk("trigOen", 32'h1, trigOen);
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_HCOUNT, 32'h30C);
        rd(ADDR_LINES, 32'h20D);
        rd(ADDR_PULSE, 32'h1);
        wr(8'h18, 32'hFFFFFFFF);
        rd(8'h18, 32'h0);
        rd(ADDR_CMD, 32'h0);
        wr(ADDR_LINES, 32'h271);
        rd(ADDR_LINES, 32'h271);
        wr(ADDR_HCOUNT, 32'hFFFFFFFF);
        rd(ADDR_HCOUNT, 32'h7FF);
        tSync(1'b0, 32'h30C, 1'b1, 32'h271, 1'b0);
        tSync(1'b1, 32'h7FF, 1'b0, 32'h8, 1'b1);
        lumaOnly <= 1'b0;
        tTrigIn(1'b1);
        tTrigIn(1'b0);
        tOut(32'h88, 32'h0, 19, 20, 20);
        tOut(32'h08, 32'h0, 0, 0, 20);
        tOut(32'h28, 32'h0, 2600, 2620, 20000);
        tOut(32'h48, 32'h0, 3999, 4001, 20000);
        tOut(32'h68, 32'h5, 5, 5, 20);
        tOut(32'h68, 32'h0, 0, 0, 20);
        test_done();
    end

    // watchdog past the expected run of about 92300 cycles
    initial
    begin
        repeat (98000) @(posedge clk_sys);
        error_cnt++;
        test_done();
    end
endmodule
